// *** common/umr_defs.svh ***
`ifndef UMR_DEFS_SVH
`define UMR_DEFS_SVH

// modem control register bit positions
`define UMR_CTL_RTS_BIT 1
`define UMR_CTL_PINA_BIT 2
`define UMR_CTL_PINB_BIT 3
`define UMR_CTL_LOOP_BIT 4
// modem status register bit positions
`define UMR_MSR_RING_EDGE_BIT 2
`define UMR_MSR_RI_BIT 6
// reset values
`define UMR_CTL_RST 8'h00
`define UMR_MSR_RST 8'h00
// register addresses
`define UMR_ADDR_CTL 3'h4
`define UMR_ADDR_MSR 3'h6
// receiver clock is sixteen times the baud rate
`define UMR_RX_OVERSAMPLE 16

`endif

// *** common/umr_pkg.sv ***
package umr_pkg;

    // host read request captured on one clock
    typedef struct packed {
        logic sel;
        logic rd;
        logic [2:0] addr;
    } umr_rdreq_s;

    // pin levels toward the modem
    typedef struct packed {
        logic rts_n;
        logic pin_a_n;
        logic pin_b_n;
    } umr_modem_out_s;

    typedef enum logic [1:0] {
        UMR_RD_IDLE = 2'b00,
        UMR_RD_BUSY = 2'b01
    } umr_rdst_e;

endpackage : umr_pkg

// *** core/umr_modem_pins.sv ***
// What this block does
// - control bits 2,3 drive user pins low
// - reset and loop force user pins high
// - receiver timed from own 16x clock
// - selected read strobe places register on bus
// - msr bit 6 shows ring level
// - msr bit 2 flags ring rise
// - ring rise with enable raises interrupt
// - control bit 1 drives request-to-send low
// - reset and loop force request-to-send high
// - auto mode threshold deasserts request-to-send
// - select only when a, b high, low low
// - master reset clears registers and pins
`timescale 1ns/100ps
`default_nettype none
`include "umr_defs.svh"
module umr_modem_pins
    import umr_pkg::*;
(
    // clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic SYS_RST_IN,
    input wire logic MASTER_RESET_INPUT_IN,
    // host bus pins
    input wire logic SELECT_HIGH_A_IN,
    input wire logic SELECT_HIGH_B_IN,
    input wire logic SELECT_LOW_IN,
    input wire logic READ_STROBE_LOW_ACTIVE_IN,
    input wire logic READ_STROBE_HIGH_ACTIVE_IN,
    input wire logic [2:0] ADDR_IN,
    output logic [7:0] DATA_OUT,
    output logic DATA_OE_OUT,
    // control register write from the write path
    input wire logic CTRL_WE_IN,
    input wire logic [7:0] CTRL_WDATA_IN,
    // receiver side controls
    input wire logic AUTO_RTS_EN_IN,
    input wire logic RX_THRESHOLD_HIT_IN,
    input wire logic MSI_EN_IN,
    input wire logic RX_CLK_IN,
    // modem pins
    input wire logic RING_IN,
    output logic RTS_N_OUT,
    output logic USER_PIN_A_N_OUT,
    output logic USER_PIN_B_N_OUT,
    // status
    output logic MODEM_IRQ_OUT,
    output logic RX_SAMPLE_TICK_OUT
);
    // pins from outside the clock domain, except the address, are synchronised first;
    // active-low pins go in inverted so that the synchroniser's
    // reset value of zero means idle and no false read follows reset
    logic [7:0] raw_w;
    logic [7:0] sync_w;
    assign raw_w = {SELECT_HIGH_A_IN, SELECT_HIGH_B_IN, ~SELECT_LOW_IN,
                    ~READ_STROBE_LOW_ACTIVE_IN, READ_STROBE_HIGH_ACTIVE_IN,
                    RING_IN, RX_CLK_IN, MASTER_RESET_INPUT_IN};

    umr_sync2 #(.W(8)) u_sync (
        .clk_in(CLK_SYS_IN),
        .rst_in(SYS_RST_IN),
        .d_in(raw_w),
        .q_out(sync_w)
    );

    // all synchronised levels below are active high
    logic sel_a_s, sel_b_s, sel_l_s, rd_l_s, rd_h_s, ring_s, rclk_s, mres_s;
    assign {sel_a_s, sel_b_s, sel_l_s, rd_l_s, rd_h_s, ring_s, rclk_s,
            mres_s} = sync_w;

    // address path is held stable by the host during a strobe
    logic [2:0] addr_r;
    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) addr_r <= 3'h0;
        else addr_r <= ADDR_IN;
    end

    // decode of select and strobes
    umr_rdreq_s req_w;
    logic any_rst_w;
    assign any_rst_w = SYS_RST_IN | mres_s;
    assign req_w.sel = sel_a_s & sel_b_s & sel_l_s;
    assign req_w.rd = rd_l_s | rd_h_s;
    assign req_w.addr = addr_r;

    // read cycle tracking; one clear per strobe, not per clock
    umr_rdst_e rd_st_r, rd_st_nxt;
    logic rd_act_w, rd_start_w, msr_rd_w;
    assign rd_act_w = req_w.sel & req_w.rd;
    assign rd_start_w = rd_act_w & (rd_st_r == UMR_RD_IDLE);
    assign msr_rd_w = rd_start_w & (req_w.addr == `UMR_ADDR_MSR);

    always_comb begin
        case (rd_st_r)
            UMR_RD_IDLE: rd_st_nxt = rd_act_w ? UMR_RD_BUSY : UMR_RD_IDLE;
            UMR_RD_BUSY: rd_st_nxt = rd_act_w ? UMR_RD_BUSY : UMR_RD_IDLE;
            default: rd_st_nxt = UMR_RD_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (any_rst_w) rd_st_r <= UMR_RD_IDLE;
        else rd_st_r <= rd_st_nxt;
    end

    // modem control register
    logic [7:0] ctl_r;
    always_ff @(posedge CLK_SYS_IN) begin
        if (any_rst_w) ctl_r <= `UMR_CTL_RST;
        else if (CTRL_WE_IN) ctl_r <= CTRL_WDATA_IN;
    end

    logic loop_w;
    assign loop_w = ctl_r[`UMR_CTL_LOOP_BIT];

    // ring edge detect on the synchronised level only
    logic ring_d_r, ring_flag_r, ring_flag_nxt, ring_rise_w;
    assign ring_rise_w = ring_s & ~ring_d_r;
    // a rise in the same cycle as the read survives the clear
    assign ring_flag_nxt = ring_rise_w | (ring_flag_r & ~msr_rd_w);

    always_ff @(posedge CLK_SYS_IN) begin
        if (any_rst_w) begin
            ring_d_r <= 1'b0;
            ring_flag_r <= 1'b0;
        end else begin
            ring_d_r <= ring_s;
            ring_flag_r <= ring_flag_nxt;
        end
    end

    // status byte as read by the host; other bits belong elsewhere
    logic [7:0] msr_w;
    always_comb begin
        msr_w = `UMR_MSR_RST;
        msr_w[`UMR_MSR_RI_BIT] = ring_s;
        msr_w[`UMR_MSR_RING_EDGE_BIT] = ring_flag_r;
    end

    logic [7:0] rdata_w;
    assign rdata_w = (req_w.addr == `UMR_ADDR_MSR) ? msr_w :
                     (req_w.addr == `UMR_ADDR_CTL) ? ctl_r : 8'h00;

    // bus drive; data is captured once per strobe so the flag that the
    // read itself clears does not vanish from the bus mid-strobe
    always_ff @(posedge CLK_SYS_IN) begin
        if (any_rst_w) begin
            DATA_OUT <= 8'h00;
            DATA_OE_OUT <= 1'b0;
        end else begin
            if (rd_start_w) DATA_OUT <= rdata_w;
            DATA_OE_OUT <= rd_act_w;
        end
    end

    // pin levels: active low, forced high in loop mode
    umr_modem_out_s pins_w;
    logic rts_req_w;
    // auto mode lets the threshold win over software
    assign rts_req_w = ctl_r[`UMR_CTL_RTS_BIT] &
                       ~(AUTO_RTS_EN_IN & RX_THRESHOLD_HIT_IN);
    assign pins_w.rts_n = ~(rts_req_w & ~loop_w);
    assign pins_w.pin_a_n = ~(ctl_r[`UMR_CTL_PINA_BIT] & ~loop_w);
    assign pins_w.pin_b_n = ~(ctl_r[`UMR_CTL_PINB_BIT] & ~loop_w);

    always_ff @(posedge CLK_SYS_IN) begin
        if (any_rst_w) begin
            RTS_N_OUT <= 1'b1;
            USER_PIN_A_N_OUT <= 1'b1;
            USER_PIN_B_N_OUT <= 1'b1;
        end else begin
            RTS_N_OUT <= pins_w.rts_n;
            USER_PIN_A_N_OUT <= pins_w.pin_a_n;
            USER_PIN_B_N_OUT <= pins_w.pin_b_n;
        end
    end

    // interrupt follows flag while enabled
    always_ff @(posedge CLK_SYS_IN) begin
        if (any_rst_w) MODEM_IRQ_OUT <= 1'b0;
        else MODEM_IRQ_OUT <= MSI_EN_IN & ring_flag_nxt;
    end

    // receiver 16x clock: one tick per rising edge; limited to below 5 MHz
    logic rclk_d_r;
    always_ff @(posedge CLK_SYS_IN) begin
        if (any_rst_w) begin
            rclk_d_r <= 1'b0;
            RX_SAMPLE_TICK_OUT <= 1'b0;
        end else begin
            rclk_d_r <= rclk_s;
            RX_SAMPLE_TICK_OUT <= rclk_s & ~rclk_d_r;
        end
    end
endmodule : umr_modem_pins
`default_nettype wire

// *** core/umr_sync2.sv ***
`timescale 1ns/100ps
`default_nettype none
// two-stage synchroniser for a bus of levels
module umr_sync2 #(
    parameter int W = 1
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_r;

    // first stage read only by the second
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_r <= '0;
            q_out <= '0;
        end else begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule : umr_sync2
`default_nettype wire

// *** tb/tb_umr_modem_pins.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    num_errors++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_umr_modem_pins;
    import umr_pkg::*;
    logic CLK_SYS_IN = 0, SYS_RST_IN = 1, MASTER_RESET_INPUT_IN = 0;
    logic SELECT_HIGH_A_IN = 0, SELECT_HIGH_B_IN = 1, SELECT_LOW_IN = 0;
    logic READ_STROBE_LOW_ACTIVE_IN = 1, READ_STROBE_HIGH_ACTIVE_IN = 0;
    logic CTRL_WE_IN = 0, AUTO_RTS_EN_IN = 0, RX_THRESHOLD_HIT_IN = 0;
    logic MSI_EN_IN = 0, ring_req = 0, RX_CLK_IN, RING_IN, DATA_OE_OUT;
    logic RTS_N_OUT, USER_PIN_A_N_OUT, USER_PIN_B_N_OUT, MODEM_IRQ_OUT;
    logic RX_SAMPLE_TICK_OUT;
    logic [2:0] ADDR_IN = 3'h0;
    logic [7:0] CTRL_WDATA_IN = 8'h00, DATA_OUT;
    umr_modem_out_s pins;
    int num_errors = 0, samples_checked = 0, cyc = 0, ticks = 0;
    umr_modem_pins i_umr_modem_pins (.*);
    umr_modem_model i_umr_modem_model (.clk_in(CLK_SYS_IN),
        .ring_in(ring_req), .ring_out(RING_IN), .rx_clk_out(RX_CLK_IN));
    assign pins = {RTS_N_OUT, USER_PIN_A_N_OUT, USER_PIN_B_N_OUT};
    always #50 CLK_SYS_IN = ~CLK_SYS_IN;
    // the run needs about 85 cycles, so 2000 means a hang
    always @(posedge CLK_SYS_IN) begin
        cyc <= cyc + 1;
        ticks <= ticks + int'(RX_SAMPLE_TICK_OUT === 1'b1);
        if (cyc == 2000) begin
            num_errors++;
            stop_test();
        end
    end
    // inputs move 10 ns after the edge
    task automatic step(int n);
        repeat (n) @(posedge CLK_SYS_IN);
        #10;
    endtask : step
    task automatic wr(logic [7:0] d);
        CTRL_WDATA_IN = d;
        CTRL_WE_IN = 1;
        step(1);
        CTRL_WE_IN = 0;
        step(2);
    endtask : wr
    // only one strobe moves, the other stays at its idle level
    task automatic rd(logic [2:0] a, logic hi, logic [7:0] e, logic oe);
        ADDR_IN = a;
        if (hi) READ_STROBE_HIGH_ACTIVE_IN = 1;
        else READ_STROBE_LOW_ACTIVE_IN = 0;
        step(4);
        `CHK("oe", oe, DATA_OE_OUT)
        if (oe) `CHK("data", e, DATA_OUT)
        READ_STROBE_HIGH_ACTIVE_IN = 0;
        READ_STROBE_LOW_ACTIVE_IN = 1;
        step(4);
        `CHK("oe off", 1'b0, DATA_OE_OUT)
    endtask : rd
    task automatic stop_test();
        if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    initial begin
        step(4);
        SYS_RST_IN = 0;
        step(1);
        `CHK("reset pins", 3'b111, pins)
        rd(3'h6, 0, 8'h00, 0);
        SELECT_HIGH_A_IN = 1;
        rd(3'h1, 1, 8'h00, 1);
        wr(8'h0e);
        `CHK("drive", 3'b000, pins)
        wr(8'h1e);
        `CHK("loop", 3'b111, pins)
        wr(8'h08);
        `CHK("pin b", 3'b110, pins)
        AUTO_RTS_EN_IN = 1;
        RX_THRESHOLD_HIT_IN = 1;
        wr(8'h02);
        `CHK("auto", 3'b111, pins)
        RX_THRESHOLD_HIT_IN = 0;
        step(3);
        `CHK("rts", 3'b011, pins)
        rd(3'h4, 1, 8'h02, 1);
        MASTER_RESET_INPUT_IN = 1;
        step(4);
        `CHK("master", 3'b111, pins)
        MASTER_RESET_INPUT_IN = 0;
        MSI_EN_IN = 1;
        ring_req = 1;
        step(4);
        `CHK("irq", 1'b1, MODEM_IRQ_OUT)
        rd(3'h6, 1, 8'h44, 1);
        rd(3'h6, 0, 8'h40, 1);
        `CHK("irq clr", 1'b0, MODEM_IRQ_OUT)
        ring_req = 0;
        step(4);
        MSI_EN_IN = 0;
        ring_req = 1;
        step(4);
        `CHK("irq off", 1'b0, MODEM_IRQ_OUT)
        rd(3'h6, 0, 8'h44, 1);
        `CHK("ticks", 1'b1,
            1'((i_umr_modem_model.edges - ticks) inside {[0:2]}))
        stop_test();
    end
endmodule : tb_umr_modem_pins
`default_nettype wire

// *** tb/umr_modem_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// modem side: ring level and a free running receive clock
module umr_modem_model (
    input wire logic clk_in,
    input wire logic ring_in,
    output logic ring_out,
    output logic rx_clk_out
);
    logic [2:0] div_r = 3'h0;
    int edges = 0;
    assign ring_out = ring_in;
    // eight system cycles a period, slow enough for the synchroniser
    assign rx_clk_out = div_r[2];
    always_ff @(posedge clk_in) begin
        div_r <= div_r + 3'h1;
        edges <= edges + int'(div_r == 3'h3);
    end
endmodule : umr_modem_model
`default_nettype wire

// *** tb/umr_modem_pins_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module umr_modem_pins_asserts (
    input wire logic CLK_SYS_IN, SYS_RST_IN, MASTER_RESET_INPUT_IN,
    input wire logic SELECT_HIGH_A_IN, SELECT_HIGH_B_IN, SELECT_LOW_IN,
    input wire logic READ_STROBE_LOW_ACTIVE_IN, READ_STROBE_HIGH_ACTIVE_IN,
    input wire logic CTRL_WE_IN, AUTO_RTS_EN_IN, RX_THRESHOLD_HIT_IN,
    input wire logic MSI_EN_IN, RX_CLK_IN, RING_IN, DATA_OE_OUT, RTS_N_OUT,
    input wire logic USER_PIN_A_N_OUT, USER_PIN_B_N_OUT, MODEM_IRQ_OUT,
    input wire logic RX_SAMPLE_TICK_OUT,
    input wire logic [7:0] CTRL_WDATA_IN
);
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (SYS_RST_IN);
    logic [2:0] mres_q = 3'h0;
    logic w, sel, rd, hi;
    // master reset still in the synchroniser would mask a write
    always_ff @(posedge CLK_SYS_IN) mres_q <= {mres_q[1:0], MASTER_RESET_INPUT_IN};
    assign w = CTRL_WE_IN && !CTRL_WDATA_IN[4] && mres_q == 3'h0;
    assign sel = SELECT_HIGH_A_IN && SELECT_HIGH_B_IN && !SELECT_LOW_IN;
    assign rd = !READ_STROBE_LOW_ACTIVE_IN || READ_STROBE_HIGH_ACTIVE_IN;
    assign hi = RTS_N_OUT && USER_PIN_A_N_OUT && USER_PIN_B_N_OUT;
    pin_low_a: assert property (
        w && CTRL_WDATA_IN[2] |-> ##2 !USER_PIN_A_N_OUT) else $error("pin a");
    pin_b_high_a: assert property (
        w && !CTRL_WDATA_IN[3] |-> ##2 USER_PIN_B_N_OUT) else $error("pin b");
    loop_force_a: assert property (
        CTRL_WE_IN && CTRL_WDATA_IN[4] |-> ##2 hi) else $error("loop");
    rts_drive_a: assert property (
        w && CTRL_WDATA_IN[1] && !AUTO_RTS_EN_IN ##1 !AUTO_RTS_EN_IN
        |-> ##1 !RTS_N_OUT) else $error("rts");
    auto_rts_a: assert property (
        (AUTO_RTS_EN_IN && RX_THRESHOLD_HIT_IN)[*2] |-> RTS_N_OUT)
        else $error("auto rts");
    mres_force_a: assert property (
        MASTER_RESET_INPUT_IN[*4] |-> hi) else $error("master reset");
    read_drive_a: assert property (
        (sel && rd && !MASTER_RESET_INPUT_IN)[*4] |-> DATA_OE_OUT)
        else $error("read");
    read_idle_a: assert property (
        (!sel)[*4] |-> !DATA_OE_OUT) else $error("idle");
    ring_irq_a: assert property (
        $rose(RING_IN) && MSI_EN_IN ##1 MSI_EN_IN[*2] |-> ##1 MODEM_IRQ_OUT)
        else $error("ring irq");
    irq_gate_a: assert property (
        !MSI_EN_IN |=> !MODEM_IRQ_OUT) else $error("irq gate");
    tick_follow_a: assert property (
        $rose(RX_CLK_IN) && !MASTER_RESET_INPUT_IN |-> ##[1:4]
        RX_SAMPLE_TICK_OUT) else $error("tick");
    tick_pulse_a: assert property (
        RX_SAMPLE_TICK_OUT |=> !RX_SAMPLE_TICK_OUT) else $error("tick len");
    cover property (sel && rd && DATA_OE_OUT);
    cover property ($rose(MODEM_IRQ_OUT));
    cover property (AUTO_RTS_EN_IN && RX_THRESHOLD_HIT_IN && RTS_N_OUT);
endmodule : umr_modem_pins_asserts
bind umr_modem_pins umr_modem_pins_asserts i_umr_modem_pins_asserts (.*);
`default_nettype wire
